// ---- logic/card_config_pkg.sv ----
package card_config_pkg;

    // Main sequencer states.
    typedef enum logic [2:0] {
        WAIT_KEY,
        SLEEP,
        ISOLATE,
        WAIT_CSN,
        CONFIG
    } seq_state_type;

    localparam int CSN_W = 8;
    localparam logic [CSN_W-1:0] CSN_RESET = 8'h00;
    localparam logic [CSN_W-1:0] CSN_UNASSIGNED = 8'h00;

    // Command register layout.
    localparam int CMD_BITS = 3;
    localparam int CMD_LD_RESET_BIT = 0;
    localparam int CMD_WAIT_KEY_BIT = 1;
    localparam int CMD_CSN_CLEAR_BIT = 2;
    localparam logic [CMD_BITS-1:0] CMD_ALL = 3'h7;
    localparam logic [CMD_BITS-1:0] CMD_RESET = 3'h0;

    // A pending bit executes at age 0 and clears one cycle after it reaches age 1.
    localparam logic [1:0] CMD_EXEC_AGE = 2'h0;
    localparam logic [1:0] CMD_CLEAR_AGE = 2'h1;

    // Identifier checksum shift register.
    localparam logic [7:0] CHECKSUM_SEED = 8'h6a;

    // Output reset values.
    localparam logic LD_RESET_AT_RESET = 1'b1;
    localparam logic IOCHRDY_LEVEL = 1'b0;

endpackage

// ---- logic/cmd_link_if.sv ----
interface cmd_link_if;
    import card_config_pkg::*;

    logic wr;
    logic [CMD_BITS-1:0] wdata;
    logic [CMD_BITS-1:0] pending;
    logic [CMD_BITS-1:0] exec;

    modport store (
        input wr,
        input wdata,
        output pending,
        output exec
    );

    modport control (
        output wr,
        output wdata,
        input pending,
        input exec
    );
endinterface

// ---- logic/card_command_register.sv ----
module card_command_register (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Link to the sequencer.
    cmd_link_if.store cmd
);
    import card_config_pkg::*;

    for (genvar b = 0; b < CMD_BITS; b++) begin : g_bit
        logic pend_q;
        logic pend_d;
        logic [1:0] age_q;
        logic [1:0] age_d;

        // Only a one in the written data starts a command; zeros and
        // bits above the command field do nothing.
        always_comb begin
            pend_d = pend_q;
            age_d = age_q;
            if (pend_q) begin
                if (age_q == CMD_CLEAR_AGE) begin
                    pend_d = 1'b0;
                end else begin
                    age_d = age_q + 2'h1;
                end
            end
            if (cmd.wr && cmd.wdata[b]) begin
                pend_d = 1'b1;
                age_d = CMD_EXEC_AGE;
            end
        end

        always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
                pend_q <= 1'b0;
                age_q <= 2'h0;
            end else begin
                pend_q <= pend_d;
                age_q <= age_d;
            end
        end

        assign cmd.pending[b] = pend_q;
        assign cmd.exec[b] = pend_q && (age_q == CMD_EXEC_AGE);

        a_cmd_self_clear: assert property (@(posedge mclk_i)
            disable iff (rst_i)
            (cmd.wr && cmd.wdata[b]) ##1 (!cmd.wr)[*2] |=>
            !cmd.pending[b])
        else $error("command bit did not clear two cycles after execution");
    end

endmodule

// ---- logic/isa_card_config_control.sv ----
module isa_card_config_control (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Decoded host accesses.
    input wire logic key_detected_i,
    input wire logic wake_wr_i,
    input wire logic csn_wr_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] host_wdata_i,
    // Isolation responder.
    input wire logic iso_won_i,
    input wire logic iso_lost_i,
    input wire logic iso_read_busy_i,
    input wire logic id_bit_valid_i,
    input wire logic id_bit_i,
    // Wait-state request from the card's own logic.
    input wire logic iochrdy_hold_i,
    // Sequencer and registers.
    output card_config_pkg::seq_state_type state_o,
    output logic [card_config_pkg::CSN_W-1:0] csn_o,
    output logic [card_config_pkg::CMD_BITS-1:0] cmd_pending_o,
    output logic iso_active_o,
    output logic config_active_o,
    // Strobes and checksum to the rest of the card.
    output logic ld_reset_o,
    output logic ptr_reset_o,
    output logic [7:0] checksum_o,
    // IOCHRDY pin.
    output logic iochrdy_o,
    output logic iochrdy_oe_o
);
    import card_config_pkg::*;

    cmd_link_if cmd ();

    card_command_register u_cmd (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cmd(cmd.store)
    );

    seq_state_type state_q;
    seq_state_type state_d;
    logic [CSN_W-1:0] csn_q;
    logic [CSN_W-1:0] csn_d;
    logic ld_reset_q;
    logic ld_reset_d;
    logic ptr_reset_q;
    logic ptr_reset_d;
    logic [CMD_BITS-1:0] pend_q;
    logic iso_act_q;
    logic iso_act_d;
    logic cfg_act_q;
    logic cfg_act_d;
    logic [7:0] sum_q;
    logic [7:0] sum_d;
    logic oe_q;
    logic oe_d;
    logic pin_q;
    logic wake_hit;
    logic wake_live;

    // The command register is dead in wait-for-key, like the wake, number and isolation inputs.
    assign cmd.wr = cmd_wr_i && (state_q != WAIT_KEY);
    assign cmd.wdata = host_wdata_i[CMD_BITS-1:0];

    assign wake_live = wake_wr_i && (state_q != WAIT_KEY);
    assign wake_hit = (host_wdata_i == csn_q);

    // Sequencer and card select number.
    always_comb begin
        state_d = state_q;
        csn_d = csn_q;
        ld_reset_d = 1'b0;
        ptr_reset_d = wake_live;
        case (state_q)
            WAIT_KEY: begin
                if (key_detected_i) begin
                    state_d = SLEEP;
                end
            end
            SLEEP: begin
                if (wake_wr_i && wake_hit) begin
                    if (csn_q == CSN_UNASSIGNED) begin
                        state_d = ISOLATE;
                    end else begin
                        state_d = CONFIG;
                    end
                end
            end
            ISOLATE: begin
                if (wake_wr_i && !wake_hit) begin
                    state_d = SLEEP;
                end else if (wake_wr_i) begin
                    state_d = ISOLATE;
                end else if (iso_lost_i) begin
                    state_d = SLEEP;
                end else if (iso_won_i) begin
                    state_d = WAIT_CSN;
                end
            end
            WAIT_CSN: begin
                if (wake_wr_i && !wake_hit) begin
                    state_d = SLEEP;
                end else if (wake_wr_i) begin
                    state_d = ISOLATE;
                end else if (csn_wr_i &&
                             host_wdata_i != CSN_UNASSIGNED) begin
                    csn_d = host_wdata_i;
                    state_d = CONFIG;
                end
            end
            CONFIG: begin
                if (wake_wr_i && !wake_hit) begin
                    state_d = SLEEP;
                end
            end
            default: begin
                state_d = WAIT_KEY;
            end
        endcase
        // Commands run after the register decode and win over it.
        if (cmd.exec[CMD_LD_RESET_BIT]) begin
            ld_reset_d = 1'b1;
        end
        if (cmd.exec[CMD_CSN_CLEAR_BIT]) begin
            csn_d = CSN_RESET;
        end
        if (cmd.exec[CMD_WAIT_KEY_BIT]) begin
            state_d = WAIT_KEY;
        end
        iso_act_d = (state_d == ISOLATE) || (state_d == WAIT_CSN);
        cfg_act_d = (state_d == CONFIG);
    end

    // Bus reset reloads the logical devices through ld_reset_o.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= WAIT_KEY;
            csn_q <= CSN_RESET;
            ld_reset_q <= LD_RESET_AT_RESET;
            ptr_reset_q <= 1'b0;
            pend_q <= CMD_RESET;
            iso_act_q <= 1'b0;
            cfg_act_q <= 1'b0;
        end else begin
            state_q <= state_d;
            csn_q <= csn_d;
            ld_reset_q <= ld_reset_d;
            ptr_reset_q <= ptr_reset_d;
            pend_q <= cmd.pending;
            iso_act_q <= iso_act_d;
            cfg_act_q <= cfg_act_d;
        end
    end

    // Identifier checksum, rewound on every wake outside wait-for-key.
    always_comb begin
        sum_d = sum_q;
        if (wake_live) begin
            sum_d = CHECKSUM_SEED;
        end else if (id_bit_valid_i) begin
            sum_d = {sum_q[1] ^ sum_q[0] ^ id_bit_i, sum_q[7:1]};
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sum_q <= CHECKSUM_SEED;
        end else begin
            sum_q <= sum_d;
        end
    end

    // IOCHRDY is only pulled low, and never around isolation.
    always_comb begin
        oe_d = iochrdy_hold_i && !iso_read_busy_i &&
               (state_q != ISOLATE) && (state_d != ISOLATE);
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            oe_q <= 1'b0;
            pin_q <= IOCHRDY_LEVEL;
        end else begin
            oe_q <= oe_d;
            pin_q <= IOCHRDY_LEVEL;
        end
    end

    assign state_o = state_q;
    assign csn_o = csn_q;
    assign cmd_pending_o = pend_q;
    assign iso_active_o = iso_act_q;
    assign config_active_o = cfg_act_q;
    assign ld_reset_o = ld_reset_q;
    assign ptr_reset_o = ptr_reset_q;
    assign checksum_o = sum_q;
    assign iochrdy_o = pin_q;
    assign iochrdy_oe_o = oe_q;

    logic cmd_quiet;
    assign cmd_quiet = (cmd.exec == CMD_RESET);

    a_iso_needs_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_o == ISOLATE) |-> (csn_o == CSN_UNASSIGNED))
    else $error("card with a number is in isolation");

    a_config_only_state: assert property (@(posedge mclk_i)
        disable iff (rst_i)
        config_active_o == (state_o == CONFIG))
    else $error("config enable disagrees with sequencer state");

    a_iochrdy_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_o == ISOLATE) |-> !iochrdy_oe_o)
    else $error("IOCHRDY driven during isolation");

    a_wfk_holds: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_q == WAIT_KEY && !key_detected_i) |=>
        (state_o == WAIT_KEY && $stable(csn_o)))
    else $error("sequencer left wait-for-key without the key");

    a_key_to_sleep: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_q == WAIT_KEY && key_detected_i) |=> state_o == SLEEP)
    else $error("key did not move the card to sleep");

    a_sleep_mismatch: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_q == SLEEP && wake_wr_i && !wake_hit && cmd_quiet) |=>
        state_o == SLEEP)
    else $error("sleeping card woke on another number");

    a_wake_zero_iso: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_q == SLEEP && wake_wr_i && host_wdata_i == 8'h00 &&
         csn_q == 8'h00 && cmd_quiet) |=> state_o == ISOLATE)
    else $error("wake zero did not start isolation");

    a_wake_match_cfg: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_q == SLEEP && wake_wr_i && wake_hit && csn_q != 8'h00 &&
         cmd_quiet) |=> state_o == CONFIG)
    else $error("matching wake did not enter config");

    a_lose_to_sleep: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_q == ISOLATE && iso_lost_i && !wake_wr_i && cmd_quiet) |=>
        state_o == SLEEP)
    else $error("losing card stayed in isolation");

    a_csn_write_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
        ($changed(csn_o) && csn_o != 8'h00) |->
        ($past(state_o) == WAIT_CSN && state_o == CONFIG))
    else $error("number written outside the wait state");

    a_wake_rewinds: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wake_wr_i && state_q != WAIT_KEY) |=>
        (ptr_reset_o && checksum_o == CHECKSUM_SEED))
    else $error("wake did not rewind the data pointer");

    a_cmd_wait_key: assert property (@(posedge mclk_i) disable iff (rst_i)
        (cmd.wr && host_wdata_i[CMD_WAIT_KEY_BIT]) |->
        ##2 state_o == WAIT_KEY)
    else $error("wait command did not reach wait-for-key");

    a_cmd_csn_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
        (cmd.wr && host_wdata_i[CMD_CSN_CLEAR_BIT] && !csn_wr_i) |->
        ##2 csn_o == 8'h00)
    else $error("clear command left the number set");

    a_cmd_ld_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
        (cmd.wr && host_wdata_i[CMD_LD_RESET_BIT]) |->
        ##2 (ld_reset_o && (state_o == $past(state_o, 2) ||
             $past(host_wdata_i[CMD_WAIT_KEY_BIT], 2))))
    else $error("device reset command missing or state disturbed");

    a_full_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
        (cmd.wr && host_wdata_i[CMD_BITS-1:0] == CMD_ALL) |->
        ##2 (ld_reset_o && state_o == WAIT_KEY && csn_o == 8'h00))
    else $error("all-bits command differs from bus reset");

    c_win_to_config: cover property (@(posedge mclk_i) disable iff (rst_i)
        state_o == WAIT_CSN ##1 state_o == CONFIG);

    c_wake_config: cover property (@(posedge mclk_i) disable iff (rst_i)
        state_o == SLEEP && csn_o != 8'h00 ##1 state_o == CONFIG);

    c_full_reset: cover property (@(posedge mclk_i) disable iff (rst_i)
        cmd.wr && host_wdata_i[CMD_BITS-1:0] == CMD_ALL);

    c_iso_loss: cover property (@(posedge mclk_i) disable iff (rst_i)
        state_o == ISOLATE ##1 state_o == SLEEP);

endmodule

// ---- tb/host_model.sv ----
module host_model #(
    parameter int SETTLE = 4
) (
    // Clock.
    input wire logic mclk_i,
    // Requests towards the card.
    output logic key_o,
    output logic wake_wr_o,
    output logic csn_wr_o,
    output logic cmd_wr_o,
    output logic iso_won_o,
    output logic iso_lost_o,
    output logic [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] strobe_q = 6'h00;
    logic [7:0] data_q = 8'h00;
    assign key_o = strobe_q[0];
    assign wake_wr_o = strobe_q[1];
    assign csn_wr_o = strobe_q[2];
    assign cmd_wr_o = strobe_q[3];
    assign iso_won_o = strobe_q[4];
    assign iso_lost_o = strobe_q[5];
    assign wdata_o = data_q;
    // One request for one cycle; the data then shows its inverse so that
    // a late sample of released data cannot match by chance.
    task automatic op(input int k, input logic [7:0] d);
        @(posedge mclk_i);
        strobe_q <= 6'h01 << k;
        data_q <= d;
        @(posedge mclk_i);
        strobe_q <= 6'h00;
        data_q <= ~d;
    endtask
    task automatic settle();
        repeat (SETTLE) @(posedge mclk_i);
    endtask
endmodule

// ---- tb/isa_card_config_control_tb.sv ----
module isa_card_config_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import card_config_pkg::*;
    localparam int K_KEY = 0, K_WAKE = 1, K_CSN = 2;
    localparam int K_CMD = 3, K_WON = 4, K_LOST = 5, LIMIT = 3000;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic busy = 1'b0;
    logic id_vld = 1'b0;
    logic id_bit = 1'b0;
    logic hold = 1'b0;
    logic key, wake, csnw, cmdw, won, lost;
    logic [7:0] wdata;
    seq_state_type state_o;
    logic [7:0] csn_o, checksum_o, m_csn, m_sum, rnd;
    logic [2:0] cmd_pending_o;
    logic iso_active_o, config_active_o, ld_reset_o, ptr_reset_o;
    logic iochrdy_o, iochrdy_oe_o;
    seq_state_type m_state = WAIT_KEY;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed = 32'h2d223ab0;

    host_model i_host_model (
        .mclk_i(mclk_i), .key_o(key), .wake_wr_o(wake), .csn_wr_o(csnw),
        .cmd_wr_o(cmdw), .iso_won_o(won), .iso_lost_o(lost),
        .wdata_o(wdata)
    );
    isa_card_config_control i_isa_card_config_control (
        .mclk_i(mclk_i), .rst_i(rst_i), .key_detected_i(key),
        .wake_wr_i(wake), .csn_wr_i(csnw), .cmd_wr_i(cmdw),
        .host_wdata_i(wdata), .iso_won_i(won), .iso_lost_i(lost),
        .iso_read_busy_i(busy), .id_bit_valid_i(id_vld),
        .id_bit_i(id_bit), .iochrdy_hold_i(hold), .state_o(state_o),
        .csn_o(csn_o), .cmd_pending_o(cmd_pending_o),
        .iso_active_o(iso_active_o), .config_active_o(config_active_o),
        .ld_reset_o(ld_reset_o), .ptr_reset_o(ptr_reset_o),
        .checksum_o(checksum_o), .iochrdy_o(iochrdy_o),
        .iochrdy_oe_o(iochrdy_oe_o)
    );

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_all(input logic ptr, input logic ld);
        chk("state", 8'(m_state), 8'(state_o));
        chk("csn", m_csn, csn_o);
        chk("iso", 8'(m_state inside {ISOLATE, WAIT_CSN}),
            8'(iso_active_o));
        chk("cfg", 8'(m_state == CONFIG), 8'(config_active_o));
        chk("ptr", 8'(ptr), 8'(ptr_reset_o));
        chk("ld", 8'(ld), 8'(ld_reset_o));
        chk("sum", m_sum, checksum_o);
    endtask

    // Reference sequencer written from the documented behaviour.
    task automatic model(input int k, input logic [7:0] d);
        if (m_state == WAIT_KEY) begin
            if (k == K_KEY) m_state = SLEEP;
        end else begin
            case (k)
                K_WAKE: begin
                    m_sum = CHECKSUM_SEED;
                    if (m_state == SLEEP) begin
                        if (d == m_csn) m_state = (d == 0) ? ISOLATE : CONFIG;
                    end else if (d != m_csn) begin
                        m_state = SLEEP;
                    end else if (m_state == WAIT_CSN) begin
                        m_state = ISOLATE;
                    end
                end
                K_CSN: begin
                    if (m_state == WAIT_CSN && d != 8'h00) begin
                        m_csn = d;
                        m_state = CONFIG;
                    end
                end
                K_CMD: begin
                    if (d[2]) m_csn = 8'h00;
                    if (d[1]) m_state = WAIT_KEY;
                end
                K_WON: if (m_state == ISOLATE) m_state = WAIT_CSN;
                K_LOST: if (m_state == ISOLATE) m_state = SLEEP;
                default: ;
            endcase
        end
    endtask

    task automatic step(input int k, input logic [7:0] d);
        logic live;
        logic [2:0] p;
        live = (m_state != WAIT_KEY);
        p = (k == K_CMD && live) ? d[2:0] : 3'h0;
        i_host_model.op(k, d);
        if (k != K_CMD) model(k, d);
        #1;
        chk_all(k == K_WAKE && live, 1'b0);
        if (k == K_CMD) begin
            model(k, d);
            @(posedge mclk_i);
            #1;
            chk_all(1'b0, p[0]);
            chk("pend", 8'(p), 8'(cmd_pending_o));
            @(posedge mclk_i);
            #1;
            chk("pend", 8'(p), 8'(cmd_pending_o));
            @(posedge mclk_i);
            #1;
            chk("pend", 8'h00, 8'(cmd_pending_o));
            if (p[0]) i_host_model.settle();
        end
    endtask

    task automatic shift_id();
        logic b;
        b = 1'b0;
        for (int i = 0; i < 8; i++) begin
            b = 1'($random(seed));
            @(posedge mclk_i);
            id_vld <= 1'b1;
            id_bit <= b;
            m_sum = {m_sum[1] ^ m_sum[0] ^ b, m_sum[7:1]};
        end
        @(posedge mclk_i);
        id_vld <= 1'b0;
        id_bit <= ~b;
        #1;
        chk_all(1'b0, 1'b0);
    endtask

    task automatic iochr(input logic bv);
        @(posedge mclk_i);
        hold <= 1'b1;
        busy <= bv;
        repeat (2) @(posedge mclk_i);
        #1;
        chk("oe", 8'(!bv && m_state != ISOLATE), 8'(iochrdy_oe_o));
        chk("rdy", 8'(IOCHRDY_LEVEL), 8'(iochrdy_o));
        @(posedge mclk_i);
        hold <= 1'b0;
        busy <= 1'b0;
    endtask

    task automatic done(input string n);
        $display("test %s done", n);
    endtask

    // Bus reset for four edges; usable at start and in mid-run.
    task automatic bus_reset();
        @(posedge mclk_i);
        rst_i <= 1'b1;
        m_state = WAIT_KEY;
        m_csn = CSN_RESET;
        m_sum = CHECKSUM_SEED;
        repeat (3) @(posedge mclk_i);
        #1;
        chk_all(1'b0, LD_RESET_AT_RESET);
        chk("pend", 8'h00, 8'(cmd_pending_o));
        @(posedge mclk_i);
        rst_i <= 1'b0;
        i_host_model.settle();
        #1;
        chk_all(1'b0, 1'b0);
    endtask

    initial begin
        bus_reset();
        done("reset");
        step(K_WAKE, 8'h00);
        step(K_CSN, 8'h05);
        step(K_CMD, 8'h04);
        step(K_KEY, 8'h00);
        done("wait_key");
        step(K_WAKE, 8'h05);
        step(K_CSN, 8'h09);
        step(K_WAKE, 8'h00);
        shift_id();
        iochr(1'b0);
        step(K_LOST, 8'h00);
        step(K_WAKE, 8'h00);
        step(K_WON, 8'h00);
        step(K_CSN, 8'h00);
        rnd = 8'($random(seed));
        if (rnd == 8'h00) rnd = 8'h01;
        step(K_CSN, rnd);
        done("isolation");
        iochr(1'b0);
        iochr(1'b1);
        step(K_CMD, 8'h00);
        step(K_CMD, 8'hf8);
        step(K_CMD, 8'h01);
        step(K_WAKE, ~rnd);
        step(K_WAKE, 8'h00);
        step(K_WAKE, rnd);
        step(K_CMD, 8'h02);
        step(K_CMD, 8'h04);
        step(K_KEY, 8'h00);
        step(K_WAKE, rnd);
        step(K_CMD, 8'h04);
        step(K_CMD, 8'h03);
        done("commands");
        step(K_KEY, 8'h00);
        step(K_WAKE, 8'h00);
        step(K_WON, 8'h00);
        step(K_CSN, rnd);
        step(K_CMD, 8'h07);
        done("full_reset");
        step(K_KEY, 8'h00);
        step(K_WAKE, 8'h00);
        step(K_WON, 8'h00);
        step(K_CSN, rnd);
        bus_reset();
        step(K_WAKE, rnd);
        done("bus_reset");
        stop_test();
    end
endmodule
